// ### gtf_pkg.sv
// package for the gain, thermal and fault register group
// assumes an 8-bit register port already decoded from the two-wire control link
package gtf_pkg;

  // register offsets on the control port
  localparam logic [7:0] ADDR_GAIN_HI = 8'h39;
  localparam logic [7:0] ADDR_GAIN_MID = 8'h3a;
  localparam logic [7:0] ADDR_GAIN_LO = 8'h3b;
  localparam logic [7:0] ADDR_THERM = 8'h3c;
  localparam logic [7:0] ADDR_LIVE = 8'h4e;
  localparam logic [7:0] ADDR_STICKY = 8'h4f;
  localparam logic [7:0] ADDR_CLR = 8'h50;

  // reset values; 0x080000 is unity gain in 5.19 format
  localparam logic [7:0] RST_GAIN_HI = 8'h08;
  localparam logic [7:0] RST_GAIN_MID = 8'h00;
  localparam logic [7:0] RST_GAIN_LO = 8'h00;
  localparam logic [7:0] RST_THERM = 8'h00;
  localparam logic [7:0] RST_STICKY = 8'hff;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // thermal control field positions
  localparam int THERM_EN_BIT = 7;
  localparam int THERM_LEVEL_LSB = 5;
  localparam int THERM_RATE_LSB = 3;

  // fault bit positions, shared by live, sticky and clear registers
  localparam int FLT_OVERCURRENT = 7;
  localparam int FLT_OVERTEMP = 6;
  localparam int FLT_UNDERVOLTAGE = 5;
  localparam int FLT_BOOT_UNDER = 4;
  localparam int FLT_BOOT_OVER = 3;
  localparam int FLT_CLOCK_DETECT = 2;
  localparam int FLT_OVERVOLTAGE = 1;
  localparam int FLT_GATE_REG_UNDER = 0;

  // audio path format
  localparam int AUDIO_W = 24;
  localparam int GAIN_FRAC_BITS = 19;

  // thermal thresholds in degrees Celsius
  localparam logic [7:0] ATTACK_BASE_C = 8'h6e;
  localparam logic [7:0] ATTACK_STEP_C = 8'h0a;
  localparam logic [7:0] RELEASE_HYST_C = 8'h0a;

  // slew timing: attenuation moves in 1/16 dB steps
  localparam longint CLK_HZ = 64'd10000000;
  localparam longint STEP_PER_DB = 64'd16;
  localparam longint RATE0_MDB_S = 64'd1000;
  localparam longint RATE1_MDB_S = 64'd500;
  localparam longint RATE2_MDB_S = 64'd330;
  localparam longint RATE3_MDB_S = 64'd250;

  // cycles per 1/16 dB step at a rate given in milli-dB per second
  function automatic int step_cycles(input longint rate_mdb);
    step_cycles = int'((CLK_HZ * 64'd1000) / (STEP_PER_DB * rate_mdb));
  endfunction : step_cycles

  localparam int STEP_CYC_0 = step_cycles(RATE0_MDB_S);
  localparam int STEP_CYC_1 = step_cycles(RATE1_MDB_S);
  localparam int STEP_CYC_2 = step_cycles(RATE2_MDB_S);
  localparam int STEP_CYC_3 = step_cycles(RATE3_MDB_S);

  // thermal slew state
  typedef enum logic [1:0] {
    GTF_HOLD = 2'b00,
    GTF_ATTACK = 2'b01,
    GTF_RELEASE = 2'b10
  } gtf_therm_t;

endpackage : gtf_pkg

// ### gtf_if.sv
// carrier between the register bank and the thermal slew controller
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface gtf_if
  import gtf_pkg::*;
#(
  parameter int ATTEN_W = 8
);
  logic enable;
  logic [1:0] level;
  logic [1:0] rate;
  logic [7:0] temp;
  logic [ATTEN_W-1:0] atten;
  gtf_therm_t mode;

  modport ctrl (output enable, output level, output rate, output temp,
                input atten, input mode);
  modport therm (input enable, input level, input rate, input temp,
                 output atten, output mode);
endinterface : gtf_if
`default_nettype wire

// ### gtf_thermal.sv
// thermal slew controller: moves the gain attenuation with junction temperature
// assumes temperature in whole degrees Celsius, synchronous to i_clk
`timescale 1ns/1ns
`default_nettype none
module gtf_thermal
  import gtf_pkg::*;
#(
  parameter int ATTEN_W = 8,
  parameter int CNT_W = 22,
  parameter int STEP_0 = STEP_CYC_0,
  parameter int STEP_1 = STEP_CYC_1,
  parameter int STEP_2 = STEP_CYC_2,
  parameter int STEP_3 = STEP_CYC_3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  gtf_if.therm ifc
);

  // refuse step periods the counter cannot hold
  if (STEP_0 < 1 || STEP_1 < 1 || STEP_2 < 1 || STEP_3 < 1 ||
      longint'(STEP_0) >= (64'd1 << CNT_W) || longint'(STEP_1) >= (64'd1 << CNT_W) ||
      longint'(STEP_2) >= (64'd1 << CNT_W) || longint'(STEP_3) >= (64'd1 << CNT_W)) begin : g_chk
    $error("gtf_thermal: step period does not fit the counter");
  end

  typedef struct packed {
    gtf_therm_t st;
    logic [CNT_W-1:0] cnt;
    logic [ATTEN_W-1:0] atten;
  } gtf_therm_state_t;

  gtf_therm_state_t s_reg;
  gtf_therm_state_t s_next;
  logic [7:0] attack_c;
  logic [7:0] release_c;
  logic [CNT_W-1:0] last_cnt;
  gtf_therm_t want;

  // attack level from the code, release fixed 10 degrees below it
  always_comb begin
    attack_c = ATTACK_BASE_C + 8'(ATTACK_STEP_C * ifc.level);
    release_c = attack_c - RELEASE_HYST_C;
    case (ifc.rate)
      2'b00: last_cnt = CNT_W'(STEP_0 - 1);
      2'b01: last_cnt = CNT_W'(STEP_1 - 1);
      2'b10: last_cnt = CNT_W'(STEP_2 - 1);
      default: last_cnt = CNT_W'(STEP_3 - 1);
    endcase
    // band decision: above attack, below release, or hold in between
    if (ifc.temp > attack_c) begin
      want = GTF_ATTACK;
    end else if (ifc.temp < release_c) begin
      want = GTF_RELEASE;
    end else begin
      want = GTF_HOLD;
    end
  end

  // step timer restarts on every band change so a step never comes early
  always_comb begin
    s_next = s_reg;
    if (!ifc.enable) begin
      s_next.st = GTF_HOLD;
      s_next.cnt = '0;
      s_next.atten = '0;
    end else if (want != s_reg.st) begin
      s_next.st = want;
      s_next.cnt = '0;
    end else begin
      case (s_reg.st)
        GTF_ATTACK, GTF_RELEASE: begin
          if (s_reg.cnt == last_cnt) begin
            s_next.cnt = '0;
            if (s_reg.st == GTF_ATTACK && s_reg.atten != '1) begin
              s_next.atten = s_reg.atten + 1'b1;
            end else if (s_reg.st == GTF_RELEASE && s_reg.atten != '0) begin
              s_next.atten = s_reg.atten - 1'b1;
            end
          end else begin
            s_next.cnt = s_reg.cnt + 1'b1;
          end
        end
        default: begin
          s_next.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_reg <= '{st: GTF_HOLD, cnt: '0, atten: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ifc.atten = s_reg.atten;
  assign ifc.mode = s_reg.st;

  AST_THERM_DISABLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !ifc.enable |=> (s_reg.atten == '0 && s_reg.st == GTF_HOLD))
    else $error("attenuation not cleared while disabled");
  AST_THERM_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (ifc.enable && s_reg.st == GTF_HOLD) |=> $stable(s_reg.atten))
    else $error("attenuation moved in the hold band");
  AST_THERM_ATTACK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (ifc.enable && s_reg.st == GTF_ATTACK) |=> !(s_reg.atten < $past(s_reg.atten)))
    else $error("gain raised while above attack level");
  AST_THERM_BAND: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (ifc.enable && ifc.temp == release_c && s_reg.st == GTF_RELEASE) |=> s_reg.st == GTF_HOLD)
    else $error("release level is not 10 degrees below attack");

endmodule : gtf_thermal
`default_nettype wire

// ### gtf_regs.sv
// gain, thermal control and fault status register bank of the amplifier
// assumes the two-wire control link delivers decoded byte reads and writes
// on i_reg_*, all inputs synchronous to i_clk
// Summary of operation
// - output audio is multiplied by the signed 24-bit gain from three bytes
// - gain is 5.19 fixed point, so 0x080000 means unity
// - gain bytes reset to 0x08, 0x00, 0x00, which is 0 dB
// - thermal control bit 7 turns the temperature gain control on
// - bits 6:5 pick attack level 110, 120, 130 or 140 degrees
// - bits 4:3 pick slew 1, 0.5, 0.33 or 0.25 dB per second
// - release level sits fixed 10 degrees below the attack level
// - above attack o_thermal_atten rises, between holds, below release it falls; the audio path does not apply it
// - live status shows each fault active low, 1 meaning normal
// - bit order overcurrent, overtemp, undervolt, boot under, boot over, clock, overvolt, gate
// - sticky register goes low on any fault and stays low until cleared
// - writing 1 to a clear bit restores that sticky bit unless its fault is still live, 0 leaves it
`timescale 1ns/1ns
`default_nettype none
module gtf_regs
  import gtf_pkg::*;
#(
  parameter int ATTEN_W = 8,
  parameter int CNT_W = 22,
  parameter int STEP_0 = STEP_CYC_0,
  parameter int STEP_1 = STEP_CYC_1,
  parameter int STEP_2 = STEP_CYC_2,
  parameter int STEP_3 = STEP_CYC_3
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_fault_ok,
  input wire logic [7:0] i_junction_temp,
  input wire logic i_audio_valid,
  input wire logic [AUDIO_W-1:0] i_audio_sample,
  output logic o_audio_valid,
  output logic [AUDIO_W-1:0] o_audio_sample,
  output logic [AUDIO_W-1:0] o_out_gain,
  output logic [ATTEN_W-1:0] o_thermal_atten,
  output logic [1:0] o_thermal_mode
);

  if (ATTEN_W < 1 || ATTEN_W > 16) begin : g_chk
    $error("gtf_regs: attenuation width out of range");
  end

  typedef struct packed {
    logic [7:0] gain_hi;
    logic [7:0] gain_mid;
    logic [7:0] gain_lo;
    logic [7:0] therm;
    logic [7:0] sticky;
    logic [7:0] rdata;
    logic aud_valid;
    logic [AUDIO_W-1:0] aud_out;
  } gtf_regs_state_t;

  gtf_regs_state_t s_reg;
  gtf_regs_state_t s_next;
  logic [AUDIO_W-1:0] gain;
  logic signed [2*AUDIO_W-1:0] product;
  logic signed [2*AUDIO_W-1:0] scaled;
  logic [7:0] clr_pulse;

  // clamp a wide signed value into the audio word instead of wrapping
  function automatic logic [AUDIO_W-1:0] sat_audio(input logic signed [2*AUDIO_W-1:0] v);
    logic signed [2*AUDIO_W-1:0] hi;
    logic signed [2*AUDIO_W-1:0] lo;
    hi = (2*AUDIO_W)'({1'b0, {(AUDIO_W-1){1'b1}}});
    lo = -hi - 1;
    if (v > hi) begin
      sat_audio = {1'b0, {(AUDIO_W-1){1'b1}}};
    end else if (v < lo) begin
      sat_audio = {1'b1, {(AUDIO_W-1){1'b0}}};
    end else begin
      sat_audio = v[AUDIO_W-1:0];
    end
  endfunction : sat_audio

  gtf_if #(.ATTEN_W(ATTEN_W)) therm_if ();

  gtf_thermal #(
    .ATTEN_W(ATTEN_W),
    .CNT_W(CNT_W),
    .STEP_0(STEP_0),
    .STEP_1(STEP_1),
    .STEP_2(STEP_2),
    .STEP_3(STEP_3)
  ) u_thermal (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .ifc(therm_if.therm)
  );

  // thermal control fields steer the slew controller directly
  assign therm_if.enable = s_reg.therm[THERM_EN_BIT];
  assign therm_if.level = s_reg.therm[THERM_LEVEL_LSB +: 2];
  assign therm_if.rate = s_reg.therm[THERM_RATE_LSB +: 2];
  assign therm_if.temp = i_junction_temp;

  // gain word assembled from the three bytes, top byte carries the sign
  assign gain = {s_reg.gain_hi, s_reg.gain_mid, s_reg.gain_lo};
  assign product = $signed(i_audio_sample) * $signed(gain);
  assign scaled = product >>> GAIN_FRAC_BITS;

  // clear requests exist only in the write cycle, nothing is stored
  assign clr_pulse = (i_reg_wr && i_reg_addr == ADDR_CLR) ? i_reg_wdata : 8'h00;

  always_comb begin
    s_next = s_reg;
    // register writes; read-only and unmapped offsets ignore writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_GAIN_HI: s_next.gain_hi = i_reg_wdata;
        ADDR_GAIN_MID: s_next.gain_mid = i_reg_wdata;
        ADDR_GAIN_LO: s_next.gain_lo = i_reg_wdata;
        ADDR_THERM: s_next.therm = i_reg_wdata;
        default: s_next.therm = s_reg.therm;
      endcase
    end
    // a clear first restores the bit, then a live fault pulls it low again,
    // so a fault coincident with its clear is never lost
    s_next.sticky = (s_reg.sticky | clr_pulse) & i_fault_ok;
    // read data is captured on the read strobe and held until the next read
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_GAIN_HI: s_next.rdata = s_reg.gain_hi;
        ADDR_GAIN_MID: s_next.rdata = s_reg.gain_mid;
        ADDR_GAIN_LO: s_next.rdata = s_reg.gain_lo;
        ADDR_THERM: s_next.rdata = s_reg.therm;
        ADDR_LIVE: s_next.rdata = i_fault_ok;
        ADDR_STICKY: s_next.rdata = s_reg.sticky;
        ADDR_CLR: s_next.rdata = RD_ZERO;
        default: s_next.rdata = RD_ZERO;
      endcase
    end
    // one-cycle audio pipeline; the product is held between samples
    s_next.aud_valid = i_audio_valid;
    if (i_audio_valid) begin
      s_next.aud_out = sat_audio(scaled);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_reg <= '{gain_hi: RST_GAIN_HI, gain_mid: RST_GAIN_MID, gain_lo: RST_GAIN_LO,
                 therm: RST_THERM, sticky: RST_STICKY, rdata: RD_ZERO,
                 aud_valid: 1'b0, aud_out: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_reg_rdata = s_reg.rdata;
  assign o_audio_valid = s_reg.aud_valid;
  assign o_audio_sample = s_reg.aud_out;
  assign o_out_gain = gain;
  assign o_thermal_atten = therm_if.atten;
  assign o_thermal_mode = therm_if.mode;

  AST_STICKY_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
    1'b1 |=> ((~$past(i_fault_ok) & s_reg.sticky) == 8'h00))
    else $error("live fault did not latch in the sticky register");
  AST_STICKY_KEEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(i_reg_wr && i_reg_addr == ADDR_CLR) |=> ((s_reg.sticky & ~$past(s_reg.sticky)) == 8'h00))
    else $error("sticky bit restored without a clear");
  AST_STICKY_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == ADDR_CLR) |=>
      ((s_reg.sticky & $past(i_reg_wdata & i_fault_ok)) == $past(i_reg_wdata & i_fault_ok)))
    else $error("clear did not restore the sticky bit");
  AST_CLEAR_READS_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr == ADDR_CLR) |=> o_reg_rdata == 8'h00)
    else $error("clear register read back nonzero");
  AST_LIVE_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_rd && i_reg_addr == ADDR_LIVE) |=> o_reg_rdata == $past(i_fault_ok))
    else $error("live status read does not match the fault inputs");
  AST_GAIN_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_reg_wr && i_reg_addr == ADDR_GAIN_HI) |=> o_out_gain[23:16] == $past(i_reg_wdata))
    else $error("gain top byte not written");
  AST_AUDIO_UNITY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_audio_valid && gain == 24'h080000) |=> o_audio_valid && o_audio_sample == $past(i_audio_sample))
    else $error("unity gain altered the audio sample");
  AST_AUDIO_HALF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_audio_valid && gain == 24'h040000 && i_audio_sample == 24'h000400) |=> o_audio_sample == 24'h000200)
    else $error("half gain did not halve the sample");

endmodule : gtf_regs
`default_nettype wire

// ### gtf_host.sv
// control host model: issues byte reads and writes on the decoded register port
// assumes one clock, strobes sampled by the register bank on the rising edge
`timescale 1ns/1ns
`default_nettype none
module gtf_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd
);
  // idle values at time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  // one write strobe; a clear byte carries 1 only where a sticky bit is to be restored
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d; // released data no longer shows the old byte
  endtask : wr_reg

  // one read strobe; data is taken after the edge that samples it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask : rd_reg
endmodule : gtf_host
`default_nettype wire

// ### gtf_tb_top.sv
// self-checking bench for the gain, thermal and fault register bank
// assumes small step parameters so that thermal slewing fits a short run
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gtf_pkg::*;
  localparam int ST [4] = '{4, 8, 12, 16};
  localparam logic [7:0] RA [7] = '{8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h4f, 8'h50, 8'h77};
  localparam logic [7:0] RE [7] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_ok = 8'hff, jtemp = 8'h19, atten;
  logic reg_wr, reg_rd, aud_v_in = 1'b0, aud_v_out;
  logic [23:0] aud_in = 24'h000000, aud_out, out_gain;
  logic [1:0] mode;
  int err_total = 0;
  int check_count = 0;
  integer seed = 32'h9ed78e35;

  always #50 clk = ~clk;

  gtf_host u_gtf_host (.i_clk(clk), .i_rdata(reg_rdata), .o_addr(reg_addr), .o_wr(reg_wr),
    .o_wdata(reg_wdata), .o_rd(reg_rd));

  gtf_regs #(.STEP_0(4), .STEP_1(8), .STEP_2(12), .STEP_3(16)) u_gtf_regs (
    .i_clk(clk), .i_rstn(rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
    .i_fault_ok(fault_ok), .i_junction_temp(jtemp), .i_audio_valid(aud_v_in),
    .i_audio_sample(aud_in), .o_audio_valid(aud_v_out), .o_audio_sample(aud_out),
    .o_out_gain(out_gain), .o_thermal_atten(atten), .o_thermal_mode(mode));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // saturated 5.19 product, worked out independently of the design
  function automatic logic [23:0] exp_audio(input logic [23:0] s, input logic [23:0] g);
    logic signed [47:0] p;
    p = $signed(s) * $signed(g);
    p = p >>> 19;
    if (p > 48'sh7fffff) return 24'h7fffff;
    if (p < -48'sh800000) return 24'h800000;
    return p[23:0];
  endfunction : exp_audio

  // bounded wait for a thermal mode; a hang shows up as a mismatch
  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    check(mode, m);
  endtask : wait_mode

  task automatic set_temp(input logic [7:0] t);
    @(posedge clk);
    jtemp <= t;
  endtask : set_temp

  // watchdog sized well above the several hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    conclude();
  end

  initial begin
    logic [7:0] d, f, c, stk, a, lvl;
    logic [23:0] g, s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, clear register and an unmapped offset read as zero
    for (int i = 0; i < 7; i++) begin
      u_gtf_host.rd_reg(RA[i], d);
      check(d, RE[i]);
    end
    check(out_gain, 24'h080000);
    $display("test reset done");
    // gain bytes and scaled audio, including unity, half and saturating cases
    for (int i = 0; i < 6; i++) begin
      g = (i == 0) ? 24'h080000 : (i == 1) ? 24'h040000 : (i == 2) ? 24'h7fffff : 24'($random(seed));
      u_gtf_host.wr_reg(8'h39, g[23:16]);
      u_gtf_host.wr_reg(8'h3a, g[15:8]);
      u_gtf_host.wr_reg(8'h3b, g[7:0]);
      // the last byte lands at the edge the write task returns on; look after it settles
      #1 check(out_gain, g);
      u_gtf_host.rd_reg(8'h39, d);
      check(d, g[23:16]);
      for (int k = 0; k < 4; k++) begin
        s = (k == 0) ? 24'h7fffff : (k == 1) ? 24'h800000 :
            (k == 2 && i == 1) ? 24'h000400 : 24'($random(seed));
        @(posedge clk);
        aud_v_in <= 1'b1;
        aud_in <= s;
        @(posedge clk);
        aud_v_in <= 1'b0;
        aud_in <= ~s;
        #1 check(aud_v_out, 24'h1);
        check(aud_out, exp_audio(s, g));
      end
    end
    $display("test gain done");
    // random faults, sticky accumulation and clears with the fault gone or still present
    stk = 8'hff;
    for (int i = 0; i < 10; i++) begin
      f = 8'($random(seed));
      @(posedge clk);
      fault_ok <= f;
      u_gtf_host.rd_reg(8'h4e, d);
      check(d, f);
      stk = stk & f;
      u_gtf_host.rd_reg(8'h4f, d);
      check(d, stk);
      c = (i == 0) ? 8'hff : 8'($random(seed));
      if (i[0]) begin
        stk = (stk | c) & f;
      end else begin
        @(posedge clk);
        fault_ok <= 8'hff;
        stk = stk | c;
      end
      u_gtf_host.wr_reg(8'h50, c);
      u_gtf_host.rd_reg(8'h4f, d);
      check(d, stk);
      u_gtf_host.rd_reg(8'h50, d);
      check(d, 8'h00);
    end
    @(posedge clk);
    fault_ok <= 8'hff;
    u_gtf_host.wr_reg(8'h4e, 8'h00);
    u_gtf_host.rd_reg(8'h4e, d);
    check(d, 8'hff);
    $display("test faults done");
    // each attack level and slew code: attack, hold at boundaries, release, disable
    for (int lv = 0; lv < 4; lv++) begin
      lvl = 8'd110 + 8'd10 * lv[7:0];
      u_gtf_host.wr_reg(8'h3c, {1'b1, lv[1:0], lv[1:0], 3'b000});
      set_temp(lvl + 8'd1);
      wait_mode(2'b01);
      repeat (4 * ST[lv]) @(posedge clk);
      #1 check(atten, 8'd4);
      set_temp(lvl);
      wait_mode(2'b00);
      a = atten;
      set_temp(lvl - 8'd10);
      repeat (2 * ST[lv]) @(posedge clk);
      #1 check(atten, a);
      check(mode, 2'b00);
      set_temp(lvl - 8'd11);
      wait_mode(2'b10);
      repeat (5 * ST[lv]) @(posedge clk);
      #1 check(atten, 8'd0);
      // climbing back onto the release level while releasing must stop the slew
      set_temp(lvl - 8'd10);
      wait_mode(2'b00);
      set_temp(lvl + 8'd5);
      wait_mode(2'b01);
      u_gtf_host.wr_reg(8'h3c, 8'h00);
      repeat (2) @(posedge clk);
      #1 check(atten, 8'd0);
      check(mode, 2'b00);
    end
    $display("test thermal done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
